//--- logic/i2c_slave_defines.svh
// register offsets, field positions, reset values and bus constants of the byte-wide serial slave
// assumes inclusion by bare name from the design and testbench files
`ifndef I2C_SLAVE_DEFINES_SVH
`define I2C_SLAVE_DEFINES_SVH

// register offsets on the plain register port
`define CONFIG_ONE_OFFSET 8'h00
`define CONFIG_TWO_OFFSET 8'h01
`define BYTE_BUFFER_OFFSET 8'h02
`define SLAVE_STATUS_OFFSET 8'h03

// control bit positions
`define SLAVE_ENABLE_POS 6
`define GEN_CALL_ENABLE_POS 6

// status bit positions
`define ST_ADDR_MATCH_POS 7
`define ST_OVERRUN_POS 5
`define ST_STOP_POS 4
`define ST_DIR_READ_POS 3
`define ST_MASTER_ACK_POS 2
`define ST_TX_FULL_POS 1
`define ST_RX_FULL_POS 0

// bus addresses and counts
`define OWN_ADDR 7'h6C
`define GEN_CALL_ADDR 7'h00
`define BITS_PER_BYTE 4'h8
`define LAST_TX_BIT 4'h7

// reset values
`define BYTE_BUFFER_RESET 8'h00
`define READ_DATA_RESET 8'h00

`endif

//--- logic/i2c_slave_pkg.sv
// types shared by the serial slave and its line synchroniser
// assumes the defines header is on the include path
package i2c_slave_pkg;

   typedef enum logic [2:0] {
      st_idle,
      st_addr,
      st_addr_ack,
      st_rx,
      st_rx_ack,
      st_tx,
      st_tx_ack,
      st_tx_wait
   } phase_type;

   typedef struct packed {
      logic scl;
      logic sda;
   } lines_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_type;

   typedef struct packed {
      lines_type meta;
      lines_type sync;
   } sync_state_type;

   typedef struct packed {
      phase_type phase;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic sda_drive;
      logic scl_drive;
      logic active;
      logic [7:0] byte_buffer;
      logic slave_enable;
      logic gen_call_enable;
      logic addr_match_flag;
      logic overrun_flag;
      logic stop_flag;
      logic dir_read_flag;
      logic master_ack_flag;
      logic tx_full_flag;
      logic rx_full_flag;
      lines_type prev;
      logic [7:0] rdata;
   } state_type;

endpackage : i2c_slave_pkg

//--- logic/i2c_line_sync.sv
// two-flop synchroniser for the bus clock and data lines
// assumes the lines are asynchronous to clk_i and idle high
`timescale 1ns/1ns
`default_nettype none

module i2c_line_sync (
   input wire logic clk_i,                       // system clock
   input wire logic resetn_i,                    // synchronous reset, active low
   input wire i2c_slave_pkg::lines_type lines_i, // raw bus lines
   output i2c_slave_pkg::lines_type lines_o      // synchronised lines
);
   import i2c_slave_pkg::*;

   sync_state_type sync_reg;
   sync_state_type sync_next;

   // the first stage feeds only the second stage
   always_comb begin
      sync_next = sync_reg;
      sync_next.meta = lines_i;
      sync_next.sync = sync_reg.meta;
   end

   // reset to idle-high so no false start appears at release
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         sync_reg <= '1;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign lines_o = sync_reg.sync;

endmodule : i2c_line_sync

`default_nettype wire

//--- logic/i2c_slave_byte_interface.sv
// byte-oriented two-wire bus slave with register port, address match and clock stretching
// assumes an external pull-up on both lines and a register master that never waits
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`include "i2c_slave_defines.svh"
`default_nettype none

module i2c_slave_byte_interface (
   input wire logic clk_i,                      // system clock, 10 MHz
   input wire logic resetn_i,                   // synchronous reset, active low
   input wire i2c_slave_pkg::bus_req_type bus_i, // register address, data and strobes
   output logic [7:0] rdata_o,                  // read data, cycle after the read strobe
   input wire logic port_pin_zero_i,            // bus clock line level
   output logic port_pin_zero_o,                // bus clock drive value, always low
   output logic port_pin_zero_oe_o,             // high while stretching the clock
   input wire logic port_pin_one_i,             // bus data line level
   output logic port_pin_one_o,                 // bus data drive value, always low
   output logic port_pin_one_oe_o,              // high while pulling data low
   output logic pin_takeover_o                  // high while the slave owns both pins
);
   import i2c_slave_pkg::*;

   // ==========================================================================
   // line synchronisation and condition detection
   // ==========================================================================
   lines_type raw_lines;
   lines_type ln;
   state_type st_reg;
   state_type st_next;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic addr_hit;
   logic rx_store;
   logic rx_reject;
   logic buf_rd;
   logic stat_rd;
   logic buf_wr;

   assign raw_lines.scl = port_pin_zero_i;
   assign raw_lines.sda = port_pin_one_i;

   i2c_line_sync u_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .lines_i(raw_lines),
      .lines_o(ln)
   );

   assign scl_rise = ln.scl & ~st_reg.prev.scl;
   assign scl_fall = ~ln.scl & st_reg.prev.scl;
   assign start_seen = ln.scl & st_reg.prev.scl & st_reg.prev.sda & ~ln.sda;
   assign stop_seen = ln.scl & st_reg.prev.scl & ~st_reg.prev.sda & ln.sda;

   // ==========================================================================
   // decode helpers
   // ==========================================================================
   assign buf_rd = bus_i.rd && (bus_i.addr == `BYTE_BUFFER_OFFSET);
   assign stat_rd = bus_i.rd && (bus_i.addr == `SLAVE_STATUS_OFFSET);
   assign buf_wr = bus_i.wr && (bus_i.addr == `BYTE_BUFFER_OFFSET);
   assign addr_hit = (st_reg.shift[7:1] == `OWN_ADDR) ||
                     (st_reg.gen_call_enable && (st_reg.shift[7:1] == `GEN_CALL_ADDR));
   assign rx_store = (st_reg.phase == st_rx) && scl_fall && (st_reg.bit_cnt == `BITS_PER_BYTE)
                     && !st_reg.rx_full_flag;
   assign rx_reject = (st_reg.phase == st_rx) && scl_fall && (st_reg.bit_cnt == `BITS_PER_BYTE)
                      && st_reg.rx_full_flag;

   // moves a pending byte into the shift register or starts stretching the clock
   function automatic state_type load_tx(input state_type s);
      state_type r;
      r = s;
      if (s.tx_full_flag) begin
         r.shift = s.byte_buffer;
         r.tx_full_flag = 1'b0;
         r.sda_drive = ~s.byte_buffer[7];
         r.scl_drive = 1'b0;
         r.bit_cnt = 4'h0;
         r.phase = st_tx;
      end else begin
         r.sda_drive = 1'b0;
         r.scl_drive = 1'b1;
         r.phase = st_tx_wait;
      end
      return r;
   endfunction : load_tx

   // ==========================================================================
   // next-state logic
   // ==========================================================================
   always_comb begin
      st_next = st_reg;
      st_next.prev = ln;

      // register reads; data stands in the following cycle
      if (bus_i.rd) begin
         unique case (bus_i.addr)
            `CONFIG_ONE_OFFSET: begin
               st_next.rdata = 8'h00;
               st_next.rdata[`SLAVE_ENABLE_POS] = st_reg.slave_enable;
            end
            `CONFIG_TWO_OFFSET: begin
               st_next.rdata = 8'h00;
               st_next.rdata[`GEN_CALL_ENABLE_POS] = st_reg.gen_call_enable;
            end
            `BYTE_BUFFER_OFFSET: begin
               st_next.rdata = st_reg.byte_buffer;
            end
            `SLAVE_STATUS_OFFSET: begin
               st_next.rdata = 8'h00;
               st_next.rdata[`ST_ADDR_MATCH_POS] = st_reg.addr_match_flag;
               st_next.rdata[`ST_OVERRUN_POS] = st_reg.overrun_flag;
               st_next.rdata[`ST_STOP_POS] = st_reg.stop_flag;
               st_next.rdata[`ST_DIR_READ_POS] = st_reg.dir_read_flag;
               st_next.rdata[`ST_MASTER_ACK_POS] = st_reg.master_ack_flag;
               st_next.rdata[`ST_TX_FULL_POS] = st_reg.tx_full_flag;
               st_next.rdata[`ST_RX_FULL_POS] = st_reg.rx_full_flag;
            end
            default: begin
               st_next.rdata = 8'h00;
            end
         endcase
      end

      // read clears come first so that a hardware set in the same cycle wins
      if (stat_rd) begin
         st_next.addr_match_flag = 1'b0;
         st_next.overrun_flag = 1'b0;
         st_next.stop_flag = 1'b0;
      end
      if (buf_rd) begin
         st_next.rx_full_flag = 1'b0;
      end

      // register writes
      if (bus_i.wr) begin
         unique case (bus_i.addr)
            `CONFIG_ONE_OFFSET: st_next.slave_enable = bus_i.wdata[`SLAVE_ENABLE_POS];
            `CONFIG_TWO_OFFSET: st_next.gen_call_enable = bus_i.wdata[`GEN_CALL_ENABLE_POS];
            `BYTE_BUFFER_OFFSET: begin
               st_next.byte_buffer = bus_i.wdata;
               if (st_reg.tx_full_flag) begin
                  st_next.overrun_flag = 1'b1;
               end
               st_next.tx_full_flag = 1'b1;
            end
            default: begin
            end
         endcase
      end

      // bit-level sequencing
      unique case (st_reg.phase)
         st_idle: begin
            // only a start leaves idle; handled below
         end
         st_addr: begin
            if (scl_rise) begin
               st_next.shift = {st_reg.shift[6:0], ln.sda};
               st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
            end else if (scl_fall && (st_reg.bit_cnt == `BITS_PER_BYTE)) begin
               if (addr_hit) begin
                  st_next.sda_drive = 1'b1;
                  st_next.addr_match_flag = 1'b1;
                  st_next.dir_read_flag = st_reg.shift[0];
                  st_next.active = 1'b1;
                  st_next.phase = st_addr_ack;
               end else begin
                  st_next.active = 1'b0;
                  st_next.phase = st_idle;
               end
            end
         end
         st_addr_ack: begin
            if (scl_fall) begin
               st_next.sda_drive = 1'b0;
               st_next.bit_cnt = 4'h0;
               if (st_reg.dir_read_flag) begin
                  st_next = load_tx(st_next);
               end else begin
                  st_next.phase = st_rx;
               end
            end
         end
         st_rx: begin
            if (scl_rise) begin
               st_next.shift = {st_reg.shift[6:0], ln.sda};
               st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
            end else if (rx_store) begin
               st_next.byte_buffer = st_reg.shift;
               st_next.rx_full_flag = 1'b1;
               st_next.sda_drive = !st_reg.overrun_flag;
               st_next.phase = st_rx_ack;
            end else if (rx_reject) begin
               // the waiting byte is kept and the new one is not acknowledged
               st_next.byte_buffer = st_reg.byte_buffer;
               st_next.overrun_flag = 1'b1;
               st_next.sda_drive = 1'b0;
               st_next.phase = st_rx_ack;
            end
         end
         st_rx_ack: begin
            if (scl_fall) begin
               st_next.sda_drive = 1'b0;
               st_next.bit_cnt = 4'h0;
               st_next.phase = st_rx;
            end
         end
         st_tx: begin
            if (scl_fall) begin
               if (st_reg.bit_cnt == `LAST_TX_BIT) begin
                  st_next.sda_drive = 1'b0;
                  st_next.bit_cnt = 4'h0;
                  st_next.phase = st_tx_ack;
               end else begin
                  st_next.shift = {st_reg.shift[6:0], 1'b0};
                  st_next.sda_drive = ~st_reg.shift[6];
                  st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
               end
            end
         end
         st_tx_ack: begin
            if (scl_rise) begin
               st_next.master_ack_flag = ~ln.sda;
            end else if (scl_fall) begin
               if (st_reg.master_ack_flag) begin
                  st_next = load_tx(st_next);
               end else begin
                  // no acknowledge: wait for the stop or a repeated start
                  st_next.phase = st_idle;
               end
            end
         end
         st_tx_wait: begin
            // clock is held low here, so data may change at once
            st_next = load_tx(st_next);
         end
      endcase

      // conditions on the bus override the bit sequencing
      if (stop_seen) begin
         if (st_reg.active) begin
            st_next.stop_flag = 1'b1;
         end
         st_next.active = 1'b0;
         st_next.sda_drive = 1'b0;
         st_next.scl_drive = 1'b0;
         st_next.phase = st_idle;
      end else if (start_seen) begin
         st_next.sda_drive = 1'b0;
         st_next.scl_drive = 1'b0;
         st_next.bit_cnt = 4'h0;
         st_next.phase = st_addr;
      end

      // a disabled slave never touches the pins; the written value counts at once so no drive outlives it
      if (!st_next.slave_enable) begin
         st_next.phase = st_idle;
         st_next.sda_drive = 1'b0;
         st_next.scl_drive = 1'b0;
         st_next.active = 1'b0;
         st_next.bit_cnt = 4'h0;
      end
   end

   // ==========================================================================
   // state register
   // ==========================================================================
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         st_reg <= '0;
         st_reg.prev <= '1;
         st_reg.byte_buffer <= `BYTE_BUFFER_RESET;
         st_reg.rdata <= `READ_DATA_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================================
   // outputs
   // ==========================================================================
   assign rdata_o = st_reg.rdata;
   assign port_pin_zero_o = 1'b0;
   assign port_pin_one_o = 1'b0;
   assign port_pin_zero_oe_o = st_reg.scl_drive;
   assign port_pin_one_oe_o = st_reg.sda_drive;
   assign pin_takeover_o = st_reg.slave_enable;

   // ==========================================================================
   // assertions
   // ==========================================================================
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   property p_disabled_quiet;
      !st_reg.slave_enable |-> !port_pin_one_oe_o && !port_pin_zero_oe_o && !pin_takeover_o;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("pins driven while disabled");

   property p_match_cause;
      $rose(st_reg.addr_match_flag) |-> $past(st_reg.phase) == st_addr && $past(addr_hit);
   endproperty
   a_match_cause: assert property (p_match_cause) else $error("match flag without address hit");

   property p_ack_addr;
      st_reg.phase == st_addr_ack |-> port_pin_one_oe_o;
   endproperty
   a_ack_addr: assert property (p_ack_addr) else $error("address not acknowledged");

   property p_gc_off;
      st_reg.phase == st_addr && scl_fall && st_reg.bit_cnt == 4'h8 && st_reg.shift[7:1] == 7'h00
         && !st_reg.gen_call_enable && st_reg.slave_enable && !stop_seen && !start_seen
         |=> st_reg.phase == st_idle && !port_pin_one_oe_o;
   endproperty
   a_gc_off: assert property (p_gc_off) else $error("general call answered while off");

   property p_rx_store;
      rx_store && st_reg.slave_enable && !stop_seen && !start_seen
         |=> st_reg.rx_full_flag && st_reg.byte_buffer == $past(st_reg.shift);
   endproperty
   a_rx_store: assert property (p_rx_store) else $error("received byte not stored");

   property p_reject;
      rx_reject && !buf_wr |=> st_reg.overrun_flag && $stable(st_reg.byte_buffer) && !port_pin_one_oe_o;
   endproperty
   a_reject: assert property (p_reject) else $error("overflow byte not rejected");

   property p_buf_read;
      buf_rd && !rx_store |=> !st_reg.rx_full_flag ##1 !st_reg.rx_full_flag || $past(rx_store);
   endproperty
   a_buf_read: assert property (p_buf_read) else $error("receive-full not cleared");

   property p_tx_write;
      buf_wr |=> st_reg.tx_full_flag || st_reg.phase == st_tx;
   endproperty
   a_tx_write: assert property (p_tx_write) else $error("transmit-full not set");

   property p_stretch;
      st_reg.phase == st_tx_wait && !st_reg.tx_full_flag |-> port_pin_zero_oe_o;
   endproperty
   a_stretch: assert property (p_stretch) else $error("clock not held low");

   property p_stop_flag;
      stop_seen && st_reg.active && st_reg.slave_enable |=> st_reg.stop_flag && st_reg.phase == st_idle;
   endproperty
   a_stop_flag: assert property (p_stop_flag) else $error("stop not flagged");

   property p_status_clear;
      stat_rd && !stop_seen |=> !st_reg.stop_flag;
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("stop flag not cleared");

   property p_tx_low_change;
      (st_reg.phase == st_tx) && $changed(port_pin_one_oe_o) |-> !st_reg.prev.scl;
   endproperty
   a_tx_low_change: assert property (p_tx_low_change) else $error("data changed with clock high");

   property p_rx_byte;
      st_reg.phase == st_rx_ack ##1 st_reg.phase == st_rx;
   endproperty
   c_rx_byte: cover property (p_rx_byte);

   property p_tx_byte;
      st_reg.phase == st_addr_ack ##1 st_reg.phase == st_tx;
   endproperty
   c_tx_byte: cover property (p_tx_byte);

   // software may take a while to refill, so the window is generous
   property p_stretch_end;
      st_reg.phase == st_tx_wait ##[1:200] st_reg.phase == st_tx;
   endproperty
   c_stretch_end: cover property (p_stretch_end);

endmodule : i2c_slave_byte_interface

`default_nettype wire

//--- testbench/i2c_master_model.sv
// two-wire bus master model: start, stop, byte write and byte read over open-drain pull-downs
// assumes the bench resolves each wire from all pull-downs plus a pull-up
`timescale 1ns/1ns
`default_nettype none

module i2c_master_model (
   input wire logic clk_i, // system clock
   input wire logic scl_i, // resolved clock wire
   input wire logic sda_i, // resolved data wire
   output logic scl_low_o, // high pulls the clock wire low
   output logic sda_low_o, // high pulls the data wire low
   output logic hang_o // a stretched clock never came back
);
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
      hang_o = 1'b0;
   end
   // ==========================================
   // wire phases
   task automatic w(input int n);
      repeat (n) @(posedge clk_i);
   endtask : w
   // the slave may stretch the clock, so the wait for the wire is bounded
   task automatic rise();
      int n;
      scl_low_o <= 1'b0;
      w(1);
      for (n = 0; n < 3000 && scl_i !== 1'b1; n++) @(posedge clk_i);
      if (scl_i !== 1'b1) hang_o <= 1'b1;
      w(2);
   endtask : rise
   // low phases last six clocks or more so the slave's synchroniser keeps up
   task automatic start();
      sda_low_o <= 1'b0;
      w(4);
      rise();
      w(6);
      sda_low_o <= 1'b1;
      w(6);
      scl_low_o <= 1'b1;
      w(4);
   endtask : start
   task automatic stop();
      sda_low_o <= 1'b1;
      w(4);
      rise();
      w(6);
      sda_low_o <= 1'b0;
      w(6);
   endtask : stop
   task automatic bit_out(input logic b);
      sda_low_o <= !b;
      w(4);
      rise();
      w(4);
      scl_low_o <= 1'b1;
      w(2);
   endtask : bit_out
   task automatic bit_in(output logic b);
      sda_low_o <= 1'b0;
      w(4);
      rise();
      w(2);
      b = sda_i;
      w(2);
      scl_low_o <= 1'b1;
      w(2);
   endtask : bit_in
   // ==========================================
   // bytes, most significant bit first
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) bit_out(d[i]);
      bit_in(b);
      ack = !b;
   endtask : wr_byte
   task automatic rd_byte(output logic [7:0] d, input logic ack);
      for (int i = 7; i >= 0; i--) bit_in(d[i]);
      bit_out(!ack);
   endtask : rd_byte
endmodule : i2c_master_model

`default_nettype wire

//--- testbench/test_i2c_slave_byte_interface.sv
// self-checking bench for the serial slave: register tasks plus a bus master model
// assumes pull-ups on both wires and the register map of the defines header
`timescale 1ns/1ns
`include "i2c_slave_defines.svh"
`default_nettype none

module test_i2c_slave_byte_interface;
   import i2c_slave_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   bus_req_type bus = '0;
   logic [7:0] rdata;
   logic scl_oe, sda_oe, take, m_scl, m_sda, hang, scl, sda, ack, pz, po;
   logic [7:0] d;
   int fails = 0;
   int n_checks = 0;
   // a driven pin shows the slave's drive value, so a wrong level breaks the transfers
   assign scl = !m_scl && (!scl_oe || pz);
   assign sda = !m_sda && (!sda_oe || po);
   always #50 clk = ~clk;

   i2c_slave_byte_interface u_i2c_slave_byte_interface (.clk_i(clk), .resetn_i(resetn), .bus_i(bus),
      .rdata_o(rdata), .port_pin_zero_i(scl), .port_pin_zero_o(pz), .port_pin_zero_oe_o(scl_oe),
      .port_pin_one_i(sda), .port_pin_one_o(po), .port_pin_one_oe_o(sda_oe), .pin_takeover_o(take));
   i2c_master_model u_i2c_master_model (.clk_i(clk), .scl_i(scl), .sda_i(sda), .scl_low_o(m_scl),
      .sda_low_o(m_sda), .hang_o(hang));

   // ==========================================
   // checks and register access
   task automatic final_report();
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp8
   task automatic cmp1(input logic got, input logic exp);
      cmp8({7'h00, got}, {7'h00, exp});
   endtask : cmp1
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask : reg_wr
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      @(negedge clk);
      cmp8(rdata, e);
   endtask : chk_rd
   // a few clocks first so a flag launched by the last wire edge has landed
   task automatic chk_st(input logic [7:0] e);
      repeat (4) @(posedge clk);
      chk_rd(`SLAVE_STATUS_OFFSET, e);
   endtask : chk_st
   // wire activity always begins on a rising edge
   task automatic addr(input logic [7:0] v, input logic e);
      @(posedge clk);
      u_i2c_master_model.start();
      u_i2c_master_model.wr_byte(v, ack);
      cmp1(ack, e);
   endtask : addr
   task automatic wb(input logic [7:0] v, input logic e);
      @(posedge clk);
      u_i2c_master_model.wr_byte(v, ack);
      cmp1(ack, e);
   endtask : wb
   task automatic rb(input logic [7:0] e, input logic a);
      logic [7:0] got;
      @(posedge clk);
      u_i2c_master_model.rd_byte(got, a);
      cmp8(got, e);
   endtask : rb
   task automatic stp();
      @(posedge clk);
      u_i2c_master_model.stop();
   endtask : stp

   // ==========================================
   // scenarios
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      chk_st(8'h00);
      chk_rd(`BYTE_BUFFER_OFFSET, 8'h00);
      cmp1(take, 1'b0);
      addr(8'hD8, 1'b0);
      stp();
      $display("test idle done");
      reg_wr(`CONFIG_ONE_OFFSET, 8'h40);
      @(negedge clk);
      cmp1(take, 1'b1);
      addr(8'hD8, 1'b1);
      chk_st(8'h80);
      wb(8'hA5, 1'b1);
      chk_st(8'h01);
      chk_rd(`BYTE_BUFFER_OFFSET, 8'hA5);
      chk_st(8'h00);
      wb(8'h3C, 1'b1);
      wb(8'h5A, 1'b0);
      stp();
      chk_st(8'h31);
      chk_st(8'h01);
      chk_rd(`BYTE_BUFFER_OFFSET, 8'h3C);
      $display("test receive done");
      addr(8'hDA, 1'b0);
      stp();
      addr(8'h00, 1'b0);
      stp();
      reg_wr(`CONFIG_TWO_OFFSET, 8'h40);
      addr(8'h00, 1'b1);
      stp();
      chk_st(8'h90);
      $display("test address done");
      addr(8'hD8, 1'b1);
      reg_wr(`BYTE_BUFFER_OFFSET, 8'h11);
      reg_wr(`BYTE_BUFFER_OFFSET, 8'hC3);
      chk_st(8'hA2);
      addr(8'hD9, 1'b1);
      chk_st(8'h88);
      rb(8'hC3, 1'b1);
      chk_st(8'h0C);
      fork
         rb(8'h96, 1'b0);
         begin
            repeat (60) @(posedge clk);
            @(negedge clk);
            cmp1(scl_oe, 1'b1);
            cmp1(scl, 1'b0);
            reg_wr(`BYTE_BUFFER_OFFSET, 8'h96);
         end
      join
      chk_st(8'h08);
      stp();
      chk_st(8'h18);
      reg_wr(`CONFIG_ONE_OFFSET, 8'h00);
      @(negedge clk);
      cmp1(take, 1'b0);
      $display("test transmit done");
      final_report();
   end
   always @(posedge hang) begin
      fails++;
      final_report();
   end
   initial begin
      #2000000;
      fails++;
      final_report();
   end
endmodule : test_i2c_slave_byte_interface

`default_nettype wire
